/* dac_mode_pkg.sv */
// constants, field layout and state type for the dac mode control block
// assumes a single 200 MHz clock domain; pins are synchronised inside the block
// Overview of operation
// - each channel has an output-off bit (bit 0 left, bit 1 right); 0 keeps normal conversion running.
// - a channel whose output-off bit is 1 outputs bipolar zero and ignores its audio data.
// - de-emphasis enable at bit 4 switches de-emphasis on when 1 and resets to 0.
// - the two-bit de-emphasis rate picks 44.1 kHz (00, default), 48 kHz (01) or 32 kHz (10); 11 is reserved.
// - the three-bit format field picks right-justified 24/20/18/16, I2S (100) or left-justified (101, default).
// - rolloff select at bit 5 picks sharp rolloff at 0 (default) and slow rolloff at 1.
// - output invert at bit 0 of the flag register flips the polarity of both outputs and resets to 0.
// - flag polarity at bit 1 makes the silence flags high on zero at 0 (default) and low on zero at 1.
// - flag grouping at bit 2 gives independent flags at 0, and at 1 one common flag on the right pin only.
// - a channel is declared silent on its own once its data has been zero for 1024 word-clock periods.
// - with independent flags (grouping 0), while a channel is silent its flag is asserted, high under the default polarity.
// - a control word is bit 15 zero, a seven-bit register index in bits 14..8 and data in bits 7..0.
// - the host lowers the latch, gives sixteen clocks with one bit each, raises the latch, and the data is stored.
package dac_mode_pkg;
   // register indexes
   localparam logic [6:0] IDX_OUT_DEEMPH = 7'h13;
   localparam logic [6:0] IDX_FMT_FILT = 7'h14;
   localparam logic [6:0] IDX_ZFLAG = 7'h16;
   // reset values
   localparam logic [7:0] RST_OUT_DEEMPH = 8'h00;
   localparam logic [7:0] RST_FMT_FILT = 8'h05;
   localparam logic [7:0] RST_ZFLAG = 8'h00;
   // writable bits; reserved bits are stored as zero
   localparam logic [7:0] MASK_OUT_DEEMPH = 8'h73;
   localparam logic [7:0] MASK_FMT_FILT = 8'h27;
   localparam logic [7:0] MASK_ZFLAG = 8'h07;
   // field positions
   localparam int BIT_OFF_L = 0;
   localparam int BIT_OFF_R = 1;
   localparam int BIT_DEEMPH_EN = 4;
   localparam int BIT_RATE_LO = 5;
   localparam int BIT_FMT_LO = 0;
   localparam int BIT_ROLLOFF = 5;
   localparam int BIT_INVERT = 0;
   localparam int BIT_POLARITY = 1;
   localparam int BIT_GROUPING = 2;
   // control word layout
   localparam int WORD_BITS = 16;
   localparam int WORD_ZERO_BIT = 15;
   localparam int IDX_LO = 8;
   localparam logic [4:0] WORD_COUNT_FULL = 5'h10;
   localparam logic [4:0] WORD_COUNT_OVER = 5'h11;
   // field codes
   localparam logic [1:0] RATE_44K1 = 2'h0;
   localparam logic [1:0] RATE_48K = 2'h1;
   localparam logic [1:0] RATE_32K = 2'h2;
   localparam logic [2:0] FMT_RJ24 = 3'h0;
   localparam logic [2:0] FMT_I2S = 3'h4;
   localparam logic [2:0] FMT_LJ = 3'h5;
   // audio sample width and silence run length
   localparam int SAMPLE_W = 24;
   localparam logic [10:0] ZERO_RUN = 11'h400;
   // serial control port states, gray along idle, shift, commit
   typedef enum logic [1:0] {
      CP_IDLE = 2'b00,
      CP_SHIFT = 2'b01,
      CP_COMMIT = 2'b11
   } ctrl_state_t;
endpackage

/* dac_mode_control_zero_flags.sv */
// mode registers, serial control port and silence detect of a stereo dac
// assumes left_data/right_data come from same-clock logic and hold the word of
// the current word-clock period; all four pins are asynchronous to clk
`timescale 1ns/1ps
module dac_mode_control_zero_flags (
   input wire logic clk,
   input wire logic rst,
   input wire logic ctrl_latch,
   input wire logic ctrl_clock,
   input wire logic ctrl_serial_in,
   input wire logic word_clock,
   input wire logic [dac_mode_pkg::SAMPLE_W-1:0] left_data,
   input wire logic [dac_mode_pkg::SAMPLE_W-1:0] right_data,
   output logic [dac_mode_pkg::SAMPLE_W-1:0] left_output,
   output logic [dac_mode_pkg::SAMPLE_W-1:0] right_output,
   output logic deemph_enable,
   output logic [1:0] deemph_rate_sel,
   output logic [2:0] audio_format_sel,
   output logic rolloff_sel,
   output logic left_silence_flag,
   output logic right_silence_flag
);
   import dac_mode_pkg::*;

   // negate with saturation so full-scale negative does not wrap
   function automatic logic [SAMPLE_W-1:0] neg_sat(input logic [SAMPLE_W-1:0] v);
      logic [SAMPLE_W-1:0] r;
      r = (~v) + {{(SAMPLE_W-1){1'b0}}, 1'b1};
      if (v == {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
         r = {1'b0, {(SAMPLE_W-1){1'b1}}};
      end
      return r;
   endfunction

   // output word for one channel after off and invert controls
   function automatic logic [SAMPLE_W-1:0] shape(input logic off, input logic inv,
                                                 input logic [SAMPLE_W-1:0] d);
      logic [SAMPLE_W-1:0] r;
      r = d;
      if (off) begin
         r = '0;
      end else if (inv) begin
         r = neg_sat(d);
      end
      return r;
   endfunction

   // pin synchroniser: latch, clock, data, word clock
   logic [3:0] sync1, sync2, sync3, filt, filt_d;
   logic [3:0] next_filt;
   logic latch_rise, latch_fall, sclk_rise, wclk_rise;

   // a change is only believed once stages two and three agree
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         next_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : filt[i];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1 <= 4'hf;
         sync2 <= 4'hf;
         sync3 <= 4'hf;
         filt <= 4'hf;
         filt_d <= 4'hf;
      end else begin
         sync1 <= {word_clock, ctrl_serial_in, ctrl_clock, ctrl_latch};
         sync2 <= sync1;
         sync3 <= sync2;
         filt <= next_filt;
         filt_d <= filt;
      end
   end

   assign latch_fall = filt_d[0] && !filt[0];
   assign latch_rise = !filt_d[0] && filt[0];
   assign sclk_rise = !filt_d[1] && filt[1];
   assign wclk_rise = !filt_d[3] && filt[3];

   // serial control port
   ctrl_state_t state, next_state;
   logic [WORD_BITS-1:0] shreg, next_shreg;
   logic [4:0] bitcnt, next_bitcnt;
   logic [7:0] reg_out, reg_fmt, reg_zf;
   logic [7:0] next_reg_out, next_reg_fmt, next_reg_zf;
   logic word_ok;

   // word must be exactly sixteen bits with a zero on top
   assign word_ok = (bitcnt == WORD_COUNT_FULL) && !shreg[WORD_ZERO_BIT];

   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_reg_out = reg_out;
      next_reg_fmt = reg_fmt;
      next_reg_zf = reg_zf;
      case (state)
         CP_IDLE: begin
            if (latch_fall) begin
               next_bitcnt = '0;
               next_state = CP_SHIFT;
            end
         end
         CP_SHIFT: begin
            // one bit per control clock, msb first
            if (sclk_rise) begin
               next_shreg = {shreg[WORD_BITS-2:0], filt[2]};
               if (bitcnt != WORD_COUNT_OVER) begin
                  next_bitcnt = bitcnt + 5'h01;
               end
            end
            if (latch_rise) begin
               next_state = CP_COMMIT;
            end
         end
         CP_COMMIT: begin
            // store on latch rise; unknown indexes are dropped
            if (word_ok) begin
               if (shreg[IDX_LO +: 7] == IDX_OUT_DEEMPH) begin
                  next_reg_out = shreg[7:0] & MASK_OUT_DEEMPH;
               end else if (shreg[IDX_LO +: 7] == IDX_FMT_FILT) begin
                  next_reg_fmt = shreg[7:0] & MASK_FMT_FILT;
               end else if (shreg[IDX_LO +: 7] == IDX_ZFLAG) begin
                  next_reg_zf = shreg[7:0] & MASK_ZFLAG;
               end
            end
            next_state = CP_IDLE;
         end
         default: begin
            next_state = CP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= CP_IDLE;
         shreg <= '0;
         bitcnt <= '0;
         reg_out <= RST_OUT_DEEMPH;
         reg_fmt <= RST_FMT_FILT;
         reg_zf <= RST_ZFLAG;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         reg_out <= next_reg_out;
         reg_fmt <= next_reg_fmt;
         reg_zf <= next_reg_zf;
      end
   end

   // fields straight to the filter and interface logic
   assign deemph_enable = reg_out[BIT_DEEMPH_EN];
   assign deemph_rate_sel = reg_out[BIT_RATE_LO +: 2];
   assign audio_format_sel = reg_fmt[BIT_FMT_LO +: 3];
   assign rolloff_sel = reg_fmt[BIT_ROLLOFF];

   // sample path and silence detect, advanced once per word clock
   logic [10:0] zcnt_l, zcnt_r, next_zcnt_l, next_zcnt_r;
   logic zdet_l, zdet_r;
   logic [SAMPLE_W-1:0] next_left_output, next_right_output;
   logic next_left_flag, next_right_flag;
   logic pol;

   always_comb begin
      next_zcnt_l = zcnt_l;
      next_zcnt_r = zcnt_r;
      next_left_output = left_output;
      next_right_output = right_output;
      if (wclk_rise) begin
         // off forces zero, else optional inversion
         next_left_output = shape(reg_out[BIT_OFF_L], reg_zf[BIT_INVERT], left_data);
         next_right_output = shape(reg_out[BIT_OFF_R], reg_zf[BIT_INVERT], right_data);
         // count zero samples, restart on any nonzero
         next_zcnt_l = (left_data != '0) ? 11'h000 : ((zcnt_l == ZERO_RUN) ? zcnt_l : zcnt_l + 11'h001);
         next_zcnt_r = (right_data != '0) ? 11'h000 : ((zcnt_r == ZERO_RUN) ? zcnt_r : zcnt_r + 11'h001);
      end
   end

   assign zdet_l = (zcnt_l == ZERO_RUN);
   assign zdet_r = (zcnt_r == ZERO_RUN);
   assign pol = reg_zf[BIT_POLARITY];

   // flag pins; the unassigned left pin idles inactive
   always_comb begin
      if (reg_zf[BIT_GROUPING]) begin
         next_right_flag = (zdet_l && zdet_r) ^ pol;
         next_left_flag = pol;
      end else begin
         next_right_flag = zdet_r ^ pol;
         next_left_flag = zdet_l ^ pol;
      end
   end

   // flags register one cycle after the count so outputs are glitch free
   always_ff @(posedge clk) begin
      if (rst) begin
         zcnt_l <= '0;
         zcnt_r <= '0;
         left_output <= '0;
         right_output <= '0;
         left_silence_flag <= 1'b0;
         right_silence_flag <= 1'b0;
      end else begin
         zcnt_l <= next_zcnt_l;
         zcnt_r <= next_zcnt_r;
         left_output <= next_left_output;
         right_output <= next_right_output;
         left_silence_flag <= next_left_flag;
         right_silence_flag <= next_right_flag;
      end
   end

   property p_off_zero;
      @(posedge clk) disable iff (rst)
      wclk_rise && reg_out[BIT_OFF_L] |=> left_output == '0;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("disabled left channel not at zero");

   property p_normal;
      @(posedge clk) disable iff (rst)
      wclk_rise && !reg_out[BIT_OFF_R] && !reg_zf[BIT_INVERT] |=> right_output == $past(right_data);
   endproperty
   a_normal: assert property (p_normal) else $error("right output not following data");

   property p_invert;
      @(posedge clk) disable iff (rst)
      wclk_rise && !reg_out[BIT_OFF_L] && reg_zf[BIT_INVERT] |=> left_output == neg_sat($past(left_data));
   endproperty
   a_invert: assert property (p_invert) else $error("left output not inverted");

   property p_detect;
      @(posedge clk) disable iff (rst)
      $rose(zdet_l) |-> $past(wclk_rise) && $past(zcnt_l) == ZERO_RUN - 11'h001;
   endproperty
   a_detect: assert property (p_detect) else $error("silence declared before 1024 samples");

   property p_restart;
      @(posedge clk) disable iff (rst)
      wclk_rise && right_data != '0 |=> zcnt_r == '0 ##1 right_silence_flag == $past(pol);
   endproperty
   a_restart: assert property (p_restart) else $error("nonzero sample did not clear silence");

   property p_flag_level;
      @(posedge clk) disable iff (rst)
      !reg_zf[BIT_GROUPING] && zdet_l && !reg_zf[BIT_POLARITY] ##1 $stable(reg_zf) |-> left_silence_flag;
   endproperty
   a_flag_level: assert property (p_flag_level) else $error("left flag low while silent");

   property p_polarity;
      @(posedge clk) disable iff (rst)
      !reg_zf[BIT_GROUPING] |=> left_silence_flag == ($past(zdet_l) ^ $past(pol));
   endproperty
   a_polarity: assert property (p_polarity) else $error("flag polarity wrong");

   property p_grouping;
      @(posedge clk) disable iff (rst)
      reg_zf[BIT_GROUPING] |=> right_silence_flag == (($past(zdet_l) && $past(zdet_r)) ^ $past(pol));
   endproperty
   a_grouping: assert property (p_grouping) else $error("common flag wrong");

   property p_commit;
      @(posedge clk) disable iff (rst)
      state == CP_COMMIT && word_ok && shreg[IDX_LO +: 7] == IDX_FMT_FILT
      |=> audio_format_sel == $past(shreg[BIT_FMT_LO +: 3]) && rolloff_sel == $past(shreg[BIT_ROLLOFF]);
   endproperty
   a_commit: assert property (p_commit) else $error("format word not stored");

   property p_bad_word;
      @(posedge clk) disable iff (rst)
      state == CP_COMMIT && !word_ok |=> $stable(reg_out) && $stable(reg_fmt) && $stable(reg_zf);
   endproperty
   a_bad_word: assert property (p_bad_word) else $error("malformed word changed a register");

   property p_deemph;
      @(posedge clk) disable iff (rst)
      state == CP_COMMIT && word_ok && shreg[IDX_LO +: 7] == IDX_OUT_DEEMPH
      |=> deemph_enable == $past(shreg[BIT_DEEMPH_EN]) && deemph_rate_sel == $past(shreg[BIT_RATE_LO +: 2]);
   endproperty
   a_deemph: assert property (p_deemph) else $error("de-emphasis fields not stored");

   property p_off_zero_r;
      @(posedge clk) disable iff (rst)
      wclk_rise && reg_out[BIT_OFF_R] |=> right_output == '0;
   endproperty
   a_off_zero_r: assert property (p_off_zero_r) else $error("disabled right channel not at zero");

   // flag lags the count by one cycle, so compare against last cycle's polarity
   property p_clear_l;
      @(posedge clk) disable iff (rst)
      wclk_rise && left_data != '0 |=> zcnt_l == '0 ##1 left_silence_flag == $past(pol);
   endproperty
   a_clear_l: assert property (p_clear_l) else $error("nonzero left sample did not clear silence");

   property p_left_group;
      @(posedge clk) disable iff (rst)
      reg_zf[BIT_GROUPING] |=> left_silence_flag == $past(pol);
   endproperty
   a_left_group: assert property (p_left_group) else $error("unassigned left pin not inactive");

endmodule // dac_mode_control_zero_flags

/* ctrl_host_model.sv */
// host side of the three-wire control port: frames 16-bit words onto the pins
// assumes the bench calls send() one frame at a time from a single process
`timescale 1ns/1ps
module ctrl_host_model (
   output logic ctrl_latch,
   output logic ctrl_clock,
   output logic ctrl_serial_in
);
   // idle pins: latch high, clock parked low between frames
   initial begin
      ctrl_latch = 1'b1;
      ctrl_clock = 1'b0;
      ctrl_serial_in = 1'b0;
   end

   // latch low, sixteen bits msb first, latch high
   task automatic send(input logic [15:0] w);
      ctrl_latch = 1'b0;
      #62.5;
      for (int i = 15; i >= 0; i--) begin
         ctrl_serial_in = w[i];
         #62.5 ctrl_clock = 1'b1; // bit taken on this rise
         #62.5 ctrl_clock = 1'b0;
      end
      #62.5 ctrl_latch = 1'b1;
      // released line shows the inverse so a stale bit is never mistaken for data
      ctrl_serial_in = ~ctrl_serial_in;
      #62.5;
   endtask
endmodule // ctrl_host_model

/* tb_dac_mode_control_zero_flags.sv */
// self-checking bench for the mode registers and silence flags
// assumes the host model drives the control pins at a 125 ns bit clock
`timescale 1ns/1ps
module tb_dac_mode_control_zero_flags;
   import dac_mode_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic word_clock = 1'b0;
   logic [SAMPLE_W-1:0] left_data = '0;
   logic [SAMPLE_W-1:0] right_data = '0;
   logic ctrl_latch;
   logic ctrl_clock;
   logic ctrl_serial_in;
   logic [SAMPLE_W-1:0] left_output;
   logic [SAMPLE_W-1:0] right_output;
   logic deemph_enable;
   logic rolloff_sel;
   logic left_silence_flag;
   logic right_silence_flag;
   logic [1:0] deemph_rate_sel;
   logic [2:0] audio_format_sel;
   int failures = 0;
   int checks_done = 0;

   always #2.5 clk = ~clk;

   ctrl_host_model host_u (.ctrl_latch(ctrl_latch), .ctrl_clock(ctrl_clock), .ctrl_serial_in(ctrl_serial_in));

   dac_mode_control_zero_flags dut_u (.clk(clk), .rst(rst), .ctrl_latch(ctrl_latch), .ctrl_clock(ctrl_clock),
      .ctrl_serial_in(ctrl_serial_in), .word_clock(word_clock), .left_data(left_data), .right_data(right_data),
      .left_output(left_output), .right_output(right_output), .deemph_enable(deemph_enable),
      .deemph_rate_sel(deemph_rate_sel), .audio_format_sel(audio_format_sel), .rolloff_sel(rolloff_sel),
      .left_silence_flag(left_silence_flag), .right_silence_flag(right_silence_flag));

   // compare one value, count it, report a miss at once
   task automatic chk(input logic [SAMPLE_W-1:0] got, input logic [SAMPLE_W-1:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one register write, then room for the pin synchronisers to commit it
   task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic top = 1'b0);
      host_u.send({top, idx, d});
      repeat (12) @(posedge clk);
      #1;
   endtask

   // n word-clock periods of 17 clk; data held well around each detected rise
   task automatic sample(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r, input int n = 1);
      repeat (n) begin
         @(posedge clk);
         #1;
         left_data = l;
         right_data = r;
         repeat (4) @(posedge clk);
         #1 word_clock = 1'b1;
         repeat (8) @(posedge clk);
         #1 word_clock = 1'b0;
         repeat (4) @(posedge clk);
      end
      #1;
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // whole run is about 45k clk; this stops a hang at 80k clk
   initial begin
      #400000;
      failures++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      test_done();
   end

   initial begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(deemph_enable, 1'b0);
      chk(deemph_rate_sel, RATE_44K1);
      chk(audio_format_sel, FMT_LJ);
      chk(rolloff_sel, 1'b0);
      chk(left_silence_flag, 1'b0);
      chk(right_silence_flag, 1'b0);
      // reserved bits and codes always written as zero
      for (int k = 0; k < 3; k++) begin
         wr(IDX_OUT_DEEMPH, {1'b0, k[1:0], 1'b1, 4'h0});
         chk(deemph_enable, 1'b1);
         chk(deemph_rate_sel, k[1:0]);
      end
      chk(deemph_rate_sel, RATE_32K);
      for (int k = 0; k < 6; k++) begin
         wr(IDX_FMT_FILT, {2'b00, k[0], 2'b00, k[2:0]});
         chk(audio_format_sel, k[2:0]);
         chk(rolloff_sel, k[0]);
      end
      // words with bit 15 set or an unknown index must be dropped
      wr(IDX_FMT_FILT, 8'h00, 1'b1);
      wr(7'h15, 8'h00);
      chk(audio_format_sel, FMT_LJ);
      chk(rolloff_sel, 1'b1);
      wr(IDX_OUT_DEEMPH, 8'h00);
      chk(deemph_enable, 1'b0);
      sample(24'h123456, 24'h800000);
      chk(left_output, 24'h123456);
      chk(right_output, 24'h800000);
      wr(IDX_OUT_DEEMPH, 8'h01);
      sample(24'h123456, 24'h800000);
      chk(left_output, 24'h000000);
      chk(right_output, 24'h800000);
      wr(IDX_OUT_DEEMPH, 8'h02);
      sample(24'h123456, 24'h7fffff);
      chk(left_output, 24'h123456);
      chk(right_output, 24'h000000);
      wr(IDX_OUT_DEEMPH, 8'h00);
      wr(IDX_ZFLAG, 8'h01);
      sample(24'h123456, 24'h800000);
      chk(left_output, 24'hedcbaa);
      // most negative word saturates instead of wrapping
      chk(right_output, 24'h7fffff);
      wr(IDX_ZFLAG, 8'h00);
      // left reaches 1024 zeros one sample before right
      sample(24'h000000, 24'h000001);
      sample(24'h000000, 24'h000000, 1022);
      chk(left_silence_flag, 1'b0);
      sample(24'h000000, 24'h000000);
      chk(left_silence_flag, 1'b1);
      chk(right_silence_flag, 1'b0);
      sample(24'h000000, 24'h000000);
      chk(right_silence_flag, 1'b1);
      wr(IDX_ZFLAG, 8'h02);
      chk(left_silence_flag, 1'b0);
      chk(right_silence_flag, 1'b0);
      wr(IDX_ZFLAG, 8'h04);
      chk(right_silence_flag, 1'b1);
      chk(left_silence_flag, 1'b0);
      wr(IDX_ZFLAG, 8'h06);
      chk(right_silence_flag, 1'b0);
      chk(left_silence_flag, 1'b1);
      wr(IDX_ZFLAG, 8'h04);
      sample(24'h000000, 24'h000010);
      chk(right_silence_flag, 1'b0);
      wr(IDX_ZFLAG, 8'h00);
      chk(left_silence_flag, 1'b1);
      chk(right_silence_flag, 1'b0);
      sample(24'h000000, 24'h000000, 1023);
      chk(right_silence_flag, 1'b0);
      sample(24'h000000, 24'h000000);
      chk(right_silence_flag, 1'b1);
      sample(24'h000005, 24'h000000);
      chk(left_silence_flag, 1'b0);
      chk(right_silence_flag, 1'b1);
      test_done();
   end
endmodule // tb_dac_mode_control_zero_flags
